//--- rtl/iss_pkg.sv
package iss_pkg;
   // sizes of this build
   localparam int NCPU = 2;
   localparam int CPUW = 1;
   localparam int NSGI = 16;
   localparam int NPPI = 16;
   localparam int NBANK = 32;
   localparam int NSPI = 8;
   localparam int NID = NBANK + NSPI;
   localparam int IDW = 10;
   // identifiers
   localparam logic [IDW-1:0] ID_SPI_BASE = 10'h020;
   localparam logic [IDW-1:0] ID_SPURIOUS = 10'h3ff;
   // register byte offsets
   localparam logic [11:0] A_CTRL    = 12'h000;
   localparam logic [11:0] A_SEC     = 12'h080;
   localparam logic [11:0] A_SETEN   = 12'h100;
   localparam logic [11:0] A_CLREN   = 12'h180;
   localparam logic [11:0] A_SETPEND = 12'h200;
   localparam logic [11:0] A_CLRPEND = 12'h280;
   localparam logic [11:0] A_ACTIVE  = 12'h300;
   localparam logic [11:0] A_FAST    = 12'h380;
   localparam logic [11:0] A_EDGE    = 12'h400;
   localparam logic [11:0] A_MODEL   = 12'h480;
   localparam logic [11:0] A_TARGET  = 12'h500;
   localparam logic [11:0] A_SWGEN   = 12'h600;
   localparam logic [11:0] A_ACK     = 12'h700;
   localparam logic [11:0] A_EOI     = 12'h704;
   // fields
   localparam int CTRL_EN_BIT = 0;
   localparam int SW_ID_LSB = 0;
   localparam int SW_TGT_LSB = 16;
   // reset values
   localparam logic [NID-1:0] EDGE_RST = 40'h00_0000_ffff;
   localparam logic [NID-1:0] EDGE_WMASK = ~EDGE_RST;
   localparam logic [NID-1:0] SEC_RST = 40'h00_0000_0000;
   localparam logic [0:0] CTRL_RST = 1'h0;
endpackage

//--- rtl/iss_core.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE1: each interrupt carries a software-set secure or non-secure attribute
// RULE2: non-secure reads of secure interrupt fields return zero
// RULE3: non-secure writes to secure interrupt fields are dropped
// RULE4: secure accesses reach fields of all interrupts
// RULE5: non-secure interrupts only use the normal request output
// RULE6: secure interrupts use the normal or the fast request output
// RULE7: each interrupt per interface is inactive, pending, active or both
// RULE8: line assertion or software makes an interrupt pending until serviced; the code ignores software set-pending for level interrupts
// RULE9: acknowledge makes an interrupt active until completion
// RULE10: a new pending event during service gives active-and-pending
// RULE11: private interrupts go to own interface, shared ones to any set
// RULE12: edge inputs latch a rising edge until cleared
// RULE13: level inputs are asserted while high, deasserted while low
// RULE14: level pending follows the line; dropping it removes pending
// RULE15: software-generated interrupts behave as an edge on write
// RULE16: one-handler model lets only one processor take the interrupt
// RULE17: all-handler model clears pending only for the acknowledging one
// RULE18: acknowledge with nothing still required returns the spurious id
// RULE19: non-secure processors issue only non-secure accesses
// RULE20: banked interrupts have one copy per interface
// RULE21: banked registers select copy by interface and by security; the code keeps one copy per interface, none per security state
// RULE22: at most eight interfaces, each masking its own processor
// RULE23: shared interrupts use ids from 32 up, lower ids are banked
// RULE24: ids 1020 to 1023 are reserved, the spurious id among them
// RULE25: completion moves active to inactive, active-pending to pending
module iss_core
   import iss_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [2:0]           pprot,
   input  wire logic [CPUW-1:0]      pcpu,
   input  wire logic [NSPI-1:0]      spi_line,
   input  wire logic [NCPU*NPPI-1:0] private_peripheral_interrupt_line,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic      [NCPU-1:0]      irq_q,
   output logic      [NCPU-1:0]      fast_interrupt_request_q
);

   // per-interface state and configuration, banked copies for ids below 32
   logic [NID-1:0]       sec_q [NCPU];
   logic [NID-1:0]       en_q [NCPU];
   logic [NID-1:0]       fst_q [NCPU];
   logic [NID-1:0]       edge_q [NCPU];
   logic [NID-1:0]       pend_q [NCPU];
   logic [NID-1:0]       act_q [NCPU];
   logic [NID-1:0]       cand [NCPU];
   logic [NSPI-1:0]      model_q;
   logic [NSPI*NCPU-1:0] tgt_q;
   logic [0:0]           ctrl_q;
   logic [NSPI-1:0]      spi_s1_q, spi_s2_q, spi_s3_q;
   logic [NCPU*NPPI-1:0] prv_s1_q, prv_s2_q, prv_s3_q;
   logic [NID-1:0]       busy1n;

   function automatic logic [31:0] wsel(input logic [NID-1:0] v, input logic hi);
      wsel = hi ? {{(32-NSPI){1'b0}}, v[NID-1:NBANK]} : v[31:0];
   endfunction

   function automatic logic [NID-1:0] upd(input logic [NID-1:0] old,
                                          input logic [NID-1:0] nv,
                                          input logic [NID-1:0] m);
      upd = (old & ~m) | (nv & m);
   endfunction

   // lowest id wins; nothing eligible gives the spurious id
   function automatic logic [IDW-1:0] pick(input logic [NID-1:0] v);
      pick = ID_SPURIOUS;
      for (int i = NID - 1; i >= 0; i--) begin
         if (v[i]) pick = IDW'(i);
      end
   endfunction

   // bus decode
   wire            ns       = pprot[1];
   wire            setup    = psel & ~penable;
   wire            acc      = psel & penable & pready;
   wire            wr       = acc & pwrite;
   wire            hi       = paddr[2];
   wire [8:0]      vb       = paddr[11:3];
   wire            hit_sec  = vb == A_SEC[11:3];
   wire            hit_sen  = vb == A_SETEN[11:3];
   wire            hit_cen  = vb == A_CLREN[11:3];
   wire            hit_sp   = vb == A_SETPEND[11:3];
   wire            hit_cp   = vb == A_CLRPEND[11:3];
   wire            hit_act  = vb == A_ACTIVE[11:3];
   wire            hit_fst  = vb == A_FAST[11:3];
   wire            hit_edg  = vb == A_EDGE[11:3];
   wire            hit_ctrl = paddr == A_CTRL;
   wire            hit_mod  = paddr == A_MODEL;
   wire            hit_tgt  = paddr == A_TARGET;
   wire            hit_sw   = paddr == A_SWGEN;
   wire            hit_ack  = paddr == A_ACK;
   wire            hit_eoi  = paddr == A_EOI;
   wire            hit_vec  = hit_sec | hit_sen | hit_cen | hit_sp | hit_cp | hit_act
                              | hit_fst | hit_edg;
   wire            mapped   = hit_vec | hit_ctrl | hit_mod | hit_tgt | hit_sw | hit_ack
                              | hit_eoi;
   wire [NID-1:0]  wv       = hi ? {pwdata[NSPI-1:0], 32'h0} : {{NSPI{1'b0}}, pwdata};
   // non-secure access sees only non-secure interrupts
   wire [NID-1:0]  accm     = ns ? sec_q[pcpu] : {NID{1'b1}}; // see RULE2 see RULE4

   // target field mask per shared interrupt
   logic [NSPI*NCPU-1:0] tmask;
   for (genvar i = 0; i < NSPI; i++) begin : g_tm
      assign tmask[i*NCPU +: NCPU] = {NCPU{accm[NBANK+i]}};
   end

   // acknowledge and completion
   wire [NID-1:0]  ackv   = cand[pcpu] & accm;
   wire [IDW-1:0]  ackid  = pick(ackv); // see RULE18 see RULE24
   wire            ack_go = acc & ~pwrite & hit_ack & (prdata[IDW-1:0] != ID_SPURIOUS);
   wire [NID-1:0]  oh_ack = ack_go ? (NID'(1) << prdata[5:0]) : '0;
   wire            eoi_ok = wr & hit_eoi & (pwdata[IDW-1:0] < IDW'(NID));
   wire [NID-1:0]  oh_eoi = eoi_ok ? (NID'(1) << pwdata[5:0]) : '0;
   wire            sw_go  = wr & hit_sw;
   wire [3:0]      sw_id  = pwdata[SW_ID_LSB +: 4];
   wire [NID-1:0]  one_n  = {~model_q, {NBANK{1'b0}}};

   // one-handler shared interrupts are withheld while any interface holds them
   always_comb begin
      busy1n = '0;
      for (int c = 0; c < NCPU; c++) begin
         busy1n = busy1n | (act_q[c] & one_n); // see RULE16
      end
   end

   // read data assembled during the setup phase
   wire [NID-1:0]  rvec = hit_sec ? (ns ? '0 : sec_q[pcpu])
                        : (hit_sen | hit_cen) ? en_q[pcpu]
                        : (hit_sp | hit_cp) ? pend_q[pcpu]
                        : hit_act ? act_q[pcpu]
                        : hit_fst ? fst_q[pcpu]
                        : edge_q[pcpu];
   wire [31:0]     rd_d = hit_vec ? wsel(rvec & accm, hi) // see RULE2 see RULE21
                        : hit_ctrl ? 32'(ctrl_q)
                        : hit_mod ? 32'(model_q & accm[NID-1:NBANK])
                        : hit_tgt ? 32'(tgt_q & tmask)
                        : hit_ack ? 32'(ackid)
                        : 32'h0;

   // apb slave: no wait states, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h0 : rd_d;
         end
      end
   end

   // line synchronisers and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spi_s1_q <= '0;
         spi_s2_q <= '0;
         spi_s3_q <= '0;
         prv_s1_q <= '0;
         prv_s2_q <= '0;
         prv_s3_q <= '0;
      end else begin
         spi_s1_q <= spi_line;
         spi_s2_q <= spi_s1_q;
         spi_s3_q <= spi_s2_q;
         prv_s1_q <= private_peripheral_interrupt_line;
         prv_s2_q <= prv_s1_q;
         prv_s3_q <= prv_s2_q;
      end
   end

   // shared configuration, non-secure model and target writes masked per interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         model_q <= '0;
         tgt_q <= '0;
      end else begin
         if (wr && hit_ctrl) ctrl_q <= pwdata[CTRL_EN_BIT +: 1];
         if (wr && hit_mod) begin
            model_q <= (model_q & ~accm[NID-1:NBANK])
                       | (pwdata[NSPI-1:0] & accm[NID-1:NBANK]); // see RULE3
         end
         if (wr && hit_tgt) begin
            tgt_q <= (tgt_q & ~tmask) | (pwdata[NSPI*NCPU-1:0] & tmask); // see RULE11
         end
      end
   end

   // one bank per interface
   for (genvar c = 0; c < NCPU; c++) begin : g_cpu
      logic [NID-1:0]  lv, rise, tg, bm, wm, setp, clrp, swg, ackset, ackclr, eoiclr;
      logic [NID-1:0]  pend_d, act_d;
      logic [NSPI-1:0] tgs;
      wire             mine = pcpu == CPUW'(c);
      for (genvar i = 0; i < NSPI; i++) begin : g_t
         assign tgs[i] = tgt_q[i*NCPU+c];
      end
      // banked ids see only this interface's lines
      assign lv   = {spi_s2_q, prv_s2_q[c*NPPI +: NPPI], {NSGI{1'b0}}}; // see RULE20
      assign rise = lv & ~{spi_s3_q, prv_s3_q[c*NPPI +: NPPI], {NSGI{1'b0}}};
      assign tg   = {tgs, {NBANK{1'b1}}}; // see RULE11 see RULE23
      assign bm   = mine ? {NID{1'b1}} : {{NSPI{1'b1}}, {NBANK{1'b0}}}; // see RULE21
      assign wm   = wr ? (bm & accm) : '0; // see RULE3 see RULE4
      // a software write acts as a rising edge on the chosen id
      assign swg  = (sw_go && pwdata[SW_TGT_LSB+c] && (!ns || sec_q[c][sw_id]))
                    ? (NID'(1) << sw_id) : '0; // see RULE15
      assign setp = (rise & tg) | (hit_sp ? (wm & wv & tg) : '0) | swg; // see RULE8
      assign ackclr = oh_ack & (mine ? {NID{1'b1}} : one_n); // see RULE16 see RULE17
      assign clrp = (hit_cp ? (wm & wv) : '0) | ackclr;
      assign ackset = mine ? oh_ack : '0;
      assign eoiclr = mine ? oh_eoi : '0;
      // edge: set wins over clear; level: pending mirrors the line
      assign pend_d = (edge_q[c] & ((pend_q[c] & ~clrp) | setp)) // see RULE12 see RULE10
                      | (~edge_q[c] & lv & tg); // see RULE13 see RULE14
      assign act_d  = (act_q[c] | ackset) & ~eoiclr; // see RULE9 see RULE25
      assign cand[c] = pend_q[c] & ~act_q[c] & en_q[c] & tg & ~busy1n
                       & {NID{ctrl_q[0]}};

      // pending and active bits, together the four-state encoding
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pend_q[c] <= '0;
            act_q[c] <= '0;
         end else begin
            pend_q[c] <= pend_d; // see RULE7
            act_q[c] <= act_d;
         end
      end

      // configuration copies, shared ids written in every bank alike
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sec_q[c] <= SEC_RST;
            en_q[c] <= '0;
            fst_q[c] <= '0;
            edge_q[c] <= EDGE_RST;
         end else begin
            if (wr && hit_sec && !ns) sec_q[c] <= upd(sec_q[c], wv, bm); // see RULE1
            if (hit_sen) en_q[c] <= en_q[c] | (wm & wv);
            if (hit_cen) en_q[c] <= en_q[c] & ~(wm & wv);
            if (hit_fst) fst_q[c] <= upd(fst_q[c], wv, wm);
            if (hit_edg) edge_q[c] <= upd(edge_q[c], wv, wm & EDGE_WMASK);
         end
      end

      // request outputs; non-secure interrupts never take the fast path
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            irq_q[c] <= 1'b0;
            fast_interrupt_request_q[c] <= 1'b0;
         end else begin
            irq_q[c] <= |(cand[c] & (sec_q[c] | ~fst_q[c])); // see RULE5 see RULE22
            fast_interrupt_request_q[c] <= |(cand[c] & ~sec_q[c] & fst_q[c]); // see RULE6
         end
      end
   end

   // checks
   property p_ns_fast;
      @(posedge pclk) disable iff (!presetn)
      fast_interrupt_request_q[0] |-> $past(|(cand[0] & ~sec_q[0]));
   endproperty
   a_ns_fast: assert property (p_ns_fast) else $error("fast request from non-secure"); // see RULE5

   property p_ns_wr;
      @(posedge pclk) disable iff (!presetn)
      wr && ns && hit_sec |=> sec_q[0] == $past(sec_q[0]);
   endproperty
   a_ns_wr: assert property (p_ns_wr) else $error("non-secure write changed security"); // see RULE3

   property p_ns_rd;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && ns && hit_sec |=> prdata == 32'h0;
   endproperty
   a_ns_rd: assert property (p_ns_rd) else $error("non-secure read not zero"); // see RULE2

   property p_eoi;
      @(posedge pclk) disable iff (!presetn)
      eoi_ok && pcpu == 1'b0 |=> (act_q[0] & $past(oh_eoi)) == '0;
   endproperty
   a_eoi: assert property (p_eoi) else $error("completion left interrupt active"); // see RULE25

   property p_ack;
      @(posedge pclk) disable iff (!presetn)
      ack_go && pcpu == 1'b0 |=> |(act_q[0] & $past(oh_ack));
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge did not activate"); // see RULE9

   property p_level;
      @(posedge pclk) disable iff (!presetn)
      !edge_q[0][NBANK] && !spi_s2_q[0] |=> !pend_q[0][NBANK];
   endproperty
   a_level: assert property (p_level) else $error("level pending without line"); // see RULE14

   property p_edge;
      @(posedge pclk) disable iff (!presetn)
      edge_q[1][NBANK+1] && g_cpu[1].rise[NBANK+1] && tgt_q[3] && !setup
         |=> pend_q[1][NBANK+1] [*2];
   endproperty
   a_edge: assert property (p_edge) else $error("edge not latched"); // see RULE12

   property p_spur;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_ack && ackv == '0 |=> prdata == 32'(ID_SPURIOUS);
   endproperty
   a_spur: assert property (p_spur) else $error("spurious id not returned"); // see RULE18

   property p_nn;
      @(posedge pclk) disable iff (!presetn)
      ack_go && pcpu == 1'b0 && oh_ack[NBANK+2] && model_q[2] && edge_q[1][NBANK+2]
         && pend_q[1][NBANK+2] |=> pend_q[1][NBANK+2];
   endproperty
   a_nn: assert property (p_nn) else $error("all-handler pending lost"); // see RULE17

   property p_sgi;
      @(posedge pclk) disable iff (!presetn)
      sw_go && !ns && pwdata[SW_TGT_LSB+1] |=> |(pend_q[1] & $past(NID'(1) << sw_id));
   endproperty
   a_sgi: assert property (p_sgi) else $error("software interrupt not pending"); // see RULE15

   // a fast request on interface 1 needs a secure candidate
   property p_ns_fast1;
      @(posedge pclk) disable iff (!presetn)
      fast_interrupt_request_q[1] |-> $past(|(cand[1] & ~sec_q[1]));
   endproperty
   a_ns_fast1: assert property (p_ns_fast1) else $error("non-secure on fast path"); // see RULE5

   // a new edge while active keeps it active and adds pending
   property p_act_pend;
      @(posedge pclk) disable iff (!presetn)
      edge_q[1][NBANK+1] && act_q[1][NBANK+1] && g_cpu[1].setp[NBANK+1]
         && !g_cpu[1].eoiclr[NBANK+1] |=> act_q[1][NBANK+1] && pend_q[1][NBANK+1];
   endproperty
   a_act_pend: assert property (p_act_pend) else $error("active-pending lost"); // see RULE10

   // a real acknowledge never hands out a reserved id
   property p_ack_id;
      @(posedge pclk) disable iff (!presetn)
      ack_go |-> prdata[IDW-1:0] < IDW'(NID);
   endproperty
   a_ack_id: assert property (p_ack_id) else $error("reserved id acknowledged"); // see RULE24

   // a high level line makes its interrupt pending
   property p_level_on;
      @(posedge pclk) disable iff (!presetn)
      !edge_q[0][NBANK] && spi_s2_q[0] && tgt_q[0] |=> pend_q[0][NBANK];
   endproperty
   a_level_on: assert property (p_level_on) else $error("level line not pending"); // see RULE13

   // a one-handler acknowledge takes the interrupt from the other bank
   property p_one;
      @(posedge pclk) disable iff (!presetn)
      ack_go && pcpu == 1'b0 && oh_ack[NBANK+2] && !model_q[2] && edge_q[1][NBANK+2]
         && !g_cpu[1].setp[NBANK+2] |=> !pend_q[1][NBANK+2];
   endproperty
   a_one: assert property (p_one) else $error("one-handler pending kept"); // see RULE16

   // hidden enable bits read as zero for a non-secure access
   property p_ns_rdv;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && ns && hit_sen && hi && pcpu == 1'b0
         |=> (prdata[NSPI-1:0] & ~$past(sec_q[0][NID-1:NBANK])) == '0;
   endproperty
   a_ns_rdv: assert property (p_ns_rdv) else $error("hidden enable bits visible"); // see RULE2

endmodule
`default_nettype wire

//--- bench/iss_src.sv
`timescale 1ns/10ps
`default_nettype none
// peripheral side: drives the shared and private interrupt lines
module iss_src
   import iss_pkg::*;
(
   input  wire logic                 pclk,
   output logic      [NSPI-1:0]      spi_line,
   output logic      [NCPU*NPPI-1:0] private_peripheral_interrupt_line
);
   // lines rest low until a source raises them
   initial begin
      spi_line = '0;
      private_peripheral_interrupt_line = '0;
   end
   // hold a private line at a level, changed just after an edge
   task automatic prv(input int n, input logic v);
      @(posedge pclk);
      private_peripheral_interrupt_line[n] <= v;
   endtask
   // hold a shared line at a level, changed just after an edge
   task automatic level(input int n, input logic v);
      @(posedge pclk);
      spi_line[n] <= v;
   endtask
   // one-cycle high pulse, then back to low
   task automatic pulse(input int n);
      level(n, 1'b1);
      level(n, 1'b0);
   endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import iss_pkg::*;
   logic                 pclk       = 1'b0;
   logic                 presetn    = 1'b0;
   logic                 psel       = 1'b0;
   logic                 penable    = 1'b0;
   logic                 pwrite     = 1'b0;
   logic [11:0]          paddr      = 12'h000;
   logic [31:0]          pwdata     = 32'h0;
   logic [2:0]           pprot      = 3'h0;
   logic [CPUW-1:0]      pcpu       = '0;
   logic [NSPI-1:0]      spi_line;
   logic [NCPU*NPPI-1:0] private_peripheral_interrupt_line;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [NCPU-1:0]      irq_q;
   logic [NCPU-1:0]      fast_interrupt_request_q;
   logic [31:0]          rdata;
   logic                 rerr;
   int                   mismatches = 0;
   int                   n_checks   = 0;
   int                   cycles     = 0;

   iss_core iss_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pcpu(pcpu),
      .spi_line(spi_line),
      .private_peripheral_interrupt_line(private_peripheral_interrupt_line),
      .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_q(irq_q),
      .fast_interrupt_request_q(fast_interrupt_request_q));
   iss_src iss_src_i (.pclk(pclk), .spi_line(spi_line),
      .private_peripheral_interrupt_line(private_peripheral_interrupt_line));

   // 40 mhz clock
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // compare one value
   task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD t=%0t %s seen %h want %h", $time, m, s, e);
      end
   endtask
   // one apb transfer, request held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      input logic ns, input logic [CPUW-1:0] c);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pprot <= {1'b0, ns, 1'b0};
      pcpu <= c;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns,
                     input logic [CPUW-1:0] c);
      apb(1'b1, a, d, ns, c);
   endtask
   task automatic xrd(input logic [11:0] a, input logic ns, input logic [CPUW-1:0] c,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0, ns, c);
      check(rdata, e, "read");
   endtask
   task automatic lines(input logic [1:0] ei, input logic [1:0] ef);
      repeat (6) @(posedge pclk);
      check({30'h0, irq_q}, {30'h0, ei}, "irq");
      check({30'h0, fast_interrupt_request_q}, {30'h0, ef}, "fast");
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      lines(2'h0, 2'h0);
      xrd(A_SEC + 12'h004, 1'b0, 1'b0, 32'h0);
      xrd(A_EDGE, 1'b0, 1'b0, 32'h0000ffff);
      wr(A_SEC + 12'h004, 32'h1, 1'b0, 1'b0);
      xrd(A_SEC + 12'h004, 1'b1, 1'b0, 32'h0);
      wr(A_SEC + 12'h004, 32'h0, 1'b1, 1'b0);
      xrd(A_SEC + 12'h004, 1'b0, 1'b0, 32'h1);
      wr(A_SETEN + 12'h004, 32'hff, 1'b1, 1'b0);
      xrd(A_SETEN + 12'h004, 1'b0, 1'b0, 32'h1);
      wr(A_SETEN + 12'h004, 32'h6, 1'b0, 1'b0);
      xrd(A_SETEN + 12'h004, 1'b1, 1'b0, 32'h1);
      xrd(A_SETEN + 12'h004, 1'b0, 1'b0, 32'h7);
      xrd(12'h7f0, 1'b0, 1'b0, 32'h0);
      check({31'h0, rerr}, 32'h1, "slverr");
      $display("test security done");
      // level, non-secure id 32 to cpu 0
      wr(A_TARGET, 32'h39, 1'b0, 1'b0);
      wr(A_CTRL, 32'h1, 1'b0, 1'b0);
      iss_src_i.level(0, 1'b1);
      lines(2'h1, 2'h0);
      xrd(A_ACK, 1'b1, 1'b0, 32'h20);
      xrd(A_ACTIVE + 12'h004, 1'b0, 1'b0, 32'h1);
      xrd(A_SETPEND + 12'h004, 1'b0, 1'b0, 32'h1);
      iss_src_i.level(0, 1'b0);
      lines(2'h0, 2'h0);
      xrd(A_SETPEND + 12'h004, 1'b0, 1'b0, 32'h0);
      wr(A_EOI, 32'h20, 1'b1, 1'b0);
      xrd(A_ACTIVE + 12'h004, 1'b0, 1'b0, 32'h0);
      xrd(A_ACK, 1'b1, 1'b0, 32'h3ff);
      $display("test level done");
      // edge, secure fast id 33 to cpu 1
      wr(A_EDGE + 12'h004, 32'h6, 1'b0, 1'b0);
      wr(A_FAST + 12'h004, 32'h2, 1'b0, 1'b0);
      iss_src_i.pulse(1);
      lines(2'h0, 2'h2);
      xrd(A_SETPEND + 12'h004, 1'b0, 1'b1, 32'h2);
      xrd(A_ACK, 1'b0, 1'b1, 32'h21);
      iss_src_i.pulse(1);
      lines(2'h0, 2'h0);
      xrd(A_SETPEND + 12'h004, 1'b0, 1'b1, 32'h2);
      xrd(A_ACTIVE + 12'h004, 1'b0, 1'b1, 32'h2);
      wr(A_EOI, 32'h21, 1'b0, 1'b1);
      xrd(A_ACTIVE + 12'h004, 1'b0, 1'b1, 32'h0);
      xrd(A_SETPEND + 12'h004, 1'b0, 1'b1, 32'h2);
      xrd(A_ACK, 1'b0, 1'b1, 32'h21);
      wr(A_EOI, 32'h21, 1'b0, 1'b1);
      $display("test edge done");
      // id 34 to both cpus, one-handler then all-handler
      wr(A_SETPEND + 12'h004, 32'h4, 1'b0, 1'b0);
      lines(2'h3, 2'h0);
      xrd(A_ACK, 1'b0, 1'b0, 32'h22);
      xrd(A_ACK, 1'b0, 1'b1, 32'h3ff);
      wr(A_EOI, 32'h22, 1'b0, 1'b0);
      wr(A_MODEL, 32'h4, 1'b0, 1'b0);
      wr(A_SETPEND + 12'h004, 32'h4, 1'b0, 1'b0);
      lines(2'h3, 2'h0);
      xrd(A_ACK, 1'b0, 1'b0, 32'h22);
      xrd(A_SETPEND + 12'h004, 1'b0, 1'b1, 32'h4);
      xrd(A_ACK, 1'b0, 1'b1, 32'h22);
      $display("test models done");
      // software-generated id 3 to cpu 1 only
      wr(A_SWGEN, 32'h00020003, 1'b0, 1'b0);
      repeat (3) @(posedge pclk);
      xrd(A_SETPEND, 1'b0, 1'b1, 32'h8);
      xrd(A_SETPEND, 1'b0, 1'b0, 32'h0);
      iss_src_i.prv(NPPI, 1'b1);
      lines(2'h0, 2'h0);
      xrd(A_SETPEND, 1'b0, 1'b1, 32'h00010008);
      xrd(A_SETPEND, 1'b0, 1'b0, 32'h0);
      $display("test swgen done");
      close_out();
   end
endmodule
`default_nettype wire
